// *** design/mhnp_top.v ***
// Host nibble port and digital control of the tone and modem device
// Operation
// - Host accesses count only while chip select low is 0.
// - With chip select and read strobe low, addressed nibble drives data lines.
// - Nibble is captured into addressed location at write strobe rising edge.
// - Data path is four bits, input on writes, output on reads.
// - Transmit bit high modulates mark, low modulates space.
// - Receive bit keeps transmit polarity, forced mark without carrier.
// - Detect flag low on carrier or progress tone detect per mode.
// - Tone pair detect output low while valid dual tone detected.
// - Modem runs 1200 bps FSK with V.23 mark and space tones.
// - Progress tone generator yields 400 Hz or 800 Hz by host choice.
// - Dual tone output has host switchable 6 dB attenuator.
// - Oscillator clock is output on a dedicated clock pin.
// - Dual tone detector input selects line or terminal path.
`include "mhnp_map.vh"
module mhnp_top (
  input wire clk,
  input wire rst_n,
  input wire chip_select_low,
  input wire read_strobe_low,
  input wire write_strobe,
  input wire addr_line_zero,
  input wire addr_line_one,
  input wire [3:0] host_nibble_in,
  output reg [3:0] host_nibble_out,
  output wire [3:0] host_nibble_oe,
  input wire tx_bit_in,
  input wire rx_demod_bit,
  input wire carrier_seen,
  input wire progress_seen,
  input wire tone_pair_seen,
  output reg rx_bit_out,
  output reg detect_flag_low,
  output reg tone_pair_detect_low,
  output wire fsk_wave,
  output wire baud_tick,
  output wire progress_tone,
  output wire tone_enable,
  output wire tone_atten_6db,
  output wire tone_pair_from_term,
  output wire power_down,
  output wire osc_clock_out
);
  // Phase steps: freq * 2^ACC_W / clk rate
  localparam [47:0] ONE_ACC = 48'h1 << `MHNP_ACC_W;
  localparam [47:0] STEP_MARK_W = (ONE_ACC * `MHNP_MARK_HZ) / `MHNP_CLK_HZ;
  localparam [47:0] STEP_SPACE_W = (ONE_ACC * `MHNP_SPACE_HZ) / `MHNP_CLK_HZ;
  localparam [47:0] STEP_BAUD_W = (ONE_ACC * `MHNP_BAUD) / `MHNP_CLK_HZ;
  localparam [47:0] STEP_LO_W = (ONE_ACC * `MHNP_CPT_LO_HZ) / `MHNP_CLK_HZ;
  localparam [47:0] STEP_HI_W = (ONE_ACC * `MHNP_CPT_HI_HZ) / `MHNP_CLK_HZ;
  localparam [47:0] STEP_OSC_W = (ONE_ACC * `MHNP_OSC_HZ) / `MHNP_CLK_HZ;
  localparam [`MHNP_ACC_W-1:0] STEP_MARK = STEP_MARK_W[`MHNP_ACC_W-1:0];
  localparam [`MHNP_ACC_W-1:0] STEP_SPACE = STEP_SPACE_W[`MHNP_ACC_W-1:0];
  localparam [`MHNP_ACC_W-1:0] STEP_BAUD = STEP_BAUD_W[`MHNP_ACC_W-1:0];
  localparam [`MHNP_ACC_W-1:0] STEP_LO = STEP_LO_W[`MHNP_ACC_W-1:0];
  localparam [`MHNP_ACC_W-1:0] STEP_HI = STEP_HI_W[`MHNP_ACC_W-1:0];
  localparam [`MHNP_ACC_W-1:0] STEP_OSC = STEP_OSC_W[`MHNP_ACC_W-1:0];

  // Reset copy, write edge history and control storage
  reg [1:0] rst_sync;
  wire rst;
  reg wr_prev;
  reg tx_bit;
  reg [3:0] ctrl [0:2];
  wire [1:0] addr;
  wire selected;
  wire wr_rise;
  wire [3:0] status_nibble;
  wire [`MHNP_ACC_W-1:0] fsk_step;
  wire [`MHNP_ACC_W-1:0] cpt_step;
  wire cpt_mode;
  genvar gi;

  // Reset release through two flops
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  // Active-high reset seen by every other process
  assign rst = ~rst_sync[1];

  assign addr = {addr_line_one, addr_line_zero};
  assign selected = ~chip_select_low;
  assign wr_rise = write_strobe & ~wr_prev;

  // Write strobe edge detector
  // History starts high so no false edge follows reset
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_prev <= 1'b1;
    end else begin
      wr_prev <= write_strobe;
    end
  end

  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_ctrl
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          ctrl[gi] <= `MHNP_CTRL_RESET;
        end else if (selected && wr_rise && addr == gi) begin
          ctrl[gi] <= host_nibble_in;
        end
      end
    end
  endgenerate

  // Status location: live detector levels, read only
  assign status_nibble = {1'b0, tone_pair_seen, progress_seen, carrier_seen};

  // read mux registered onto data lines
  // Location 3 returns status, others read back control
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      host_nibble_out <= 4'h0;
    end else if (addr == `MHNP_ADDR_STAT) begin
      host_nibble_out <= status_nibble;
    end else begin
      host_nibble_out <= ctrl[addr];
    end
  end

  // drive only during a selected read
  assign host_nibble_oe = {4{selected & ~read_strobe_low}};

  // Control field taps
  // Mode bit 0 picks the detect source, bit 1 powers down
  assign cpt_mode = ctrl[`MHNP_ADDR_MODE][`MHNP_MODE_CPT_BIT];
  assign power_down = ctrl[`MHNP_ADDR_MODE][`MHNP_MODE_PWRDN_BIT];
  assign tone_enable = ctrl[`MHNP_ADDR_TONE][`MHNP_TONE_EN_BIT];
  assign tone_atten_6db = ctrl[`MHNP_ADDR_TONE][`MHNP_TONE_ATT_BIT];
  assign tone_pair_from_term = ctrl[`MHNP_ADDR_PATH][`MHNP_PATH_TERM_BIT];

  // Transmit bit sampled at baud ticks
  // Keeps the carrier from switching in mid-bit
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_bit <= 1'b1;
    end else if (baud_tick) begin
      tx_bit <= tx_bit_in;
    end
  end

  // high is mark, low is space
  assign fsk_step = tx_bit ? STEP_MARK : STEP_SPACE;

  mhnp_nco u_baud (
    .clk(clk),
    .rst(rst),
    .enable(~power_down),
    .step(STEP_BAUD),
    .wave(),
    .tick(baud_tick)
  );

  mhnp_nco u_fsk (
    .clk(clk),
    .rst(rst),
    .enable(~power_down),
    .step(fsk_step),
    .wave(fsk_wave),
    .tick()
  );

  assign cpt_step = ctrl[`MHNP_ADDR_TONE][`MHNP_TONE_800_BIT] ? STEP_HI : STEP_LO;

  // tone accumulator held at zero while its bit is clear
  mhnp_nco u_cpt (
    .clk(clk),
    .rst(rst),
    .enable(ctrl[`MHNP_ADDR_TONE][`MHNP_TONE_PROG_BIT] & ~power_down),
    .step(cpt_step),
    .wave(progress_tone),
    .tick()
  );

  // oscillator clock out
  // Free running, never gated by power down
  mhnp_nco u_osc (
    .clk(clk),
    .rst(rst),
    .enable(1'b1),
    .step(STEP_OSC),
    .wave(osc_clock_out),
    .tick()
  );

  // Receive bit and active-low detection outputs, registered
  // Pins change only on clock edges
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_bit_out <= 1'b1;
      detect_flag_low <= 1'b1;
      tone_pair_detect_low <= 1'b1;
    end else begin
      rx_bit_out <= carrier_seen ? rx_demod_bit : 1'b1;
      detect_flag_low <= ~(cpt_mode ? progress_seen : carrier_seen);
      tone_pair_detect_low <= ~tone_pair_seen;
    end
  end
endmodule

// *** design/mhnp_map.vh ***
// Constants for the modem host nibble port
`ifndef MHNP_MAP_VH
`define MHNP_MAP_VH
// Location addresses on the port
`define MHNP_ADDR_MODE 2'h0
`define MHNP_ADDR_TONE 2'h1
`define MHNP_ADDR_PATH 2'h2
`define MHNP_ADDR_STAT 2'h3
// Reset value of every control location
`define MHNP_CTRL_RESET 4'h0
// Mode location fields
`define MHNP_MODE_CPT_BIT 0
`define MHNP_MODE_PWRDN_BIT 1
// Tone location fields
`define MHNP_TONE_EN_BIT 0
`define MHNP_TONE_800_BIT 1
`define MHNP_TONE_ATT_BIT 2
`define MHNP_TONE_PROG_BIT 3
// Path location fields
`define MHNP_PATH_TERM_BIT 0
// Clock and rates
`define MHNP_CLK_HZ 25000000
`define MHNP_OSC_HZ 3579545
`define MHNP_BAUD 1200
`define MHNP_MARK_HZ 1300
`define MHNP_SPACE_HZ 2100
`define MHNP_CPT_LO_HZ 400
`define MHNP_CPT_HI_HZ 800
// Phase accumulator width
`define MHNP_ACC_W 24
`endif

// *** design/mhnp_nco.v ***
// Phase accumulator producing a square tone or clock enable
`include "mhnp_map.vh"
module mhnp_nco (
  input wire clk,
  input wire rst,
  input wire enable,
  input wire [`MHNP_ACC_W-1:0] step,
  output reg wave,
  output reg tick
);
  reg [`MHNP_ACC_W-1:0] acc;
  wire [`MHNP_ACC_W:0] sum;

  assign sum = {1'b0, acc} + {1'b0, step};

  // Accumulate phase; tick on wrap, wave from msb
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      acc <= {`MHNP_ACC_W{1'b0}};
      wave <= 1'b0;
      tick <= 1'b0;
    end else if (enable) begin
      acc <= sum[`MHNP_ACC_W-1:0];
      wave <= sum[`MHNP_ACC_W-1];
      tick <= sum[`MHNP_ACC_W];
    end else begin
      acc <= {`MHNP_ACC_W{1'b0}};
      wave <= 1'b0;
      tick <= 1'b0;
    end
  end
endmodule

// *** tb/mhnp_props.sv ***
// Checker of the host port and detector outputs
module mhnp_props (
  input wire clk,
  input wire rst_n,
  input wire chip_select_low,
  input wire read_strobe_low,
  input wire write_strobe,
  input wire addr_line_zero,
  input wire addr_line_one,
  input wire rx_demod_bit,
  input wire carrier_seen,
  input wire tone_pair_seen,
  input wire rx_bit_out,
  input wire tone_pair_detect_low,
  input wire tone_enable,
  input wire tone_atten_6db,
  input wire tone_pair_from_term,
  input wire power_down,
  input wire [3:0] host_nibble_in,
  input wire [3:0] host_nibble_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire [1:0] adr = {addr_line_one, addr_line_zero};
  wire [3:0] ctl = {tone_enable, tone_atten_6db, tone_pair_from_term, power_down};
  // Strobe rise while selected
  sequence s_wr;
    $rose(write_strobe) && !chip_select_low;
  endsequence
  chk_oe_read:
    assert property (!chip_select_low && !read_strobe_low |-> host_nibble_oe == 4'hf)
    else $error("data lines not driven in read");
  chk_oe_release:
    assert property (chip_select_low || read_strobe_low |-> host_nibble_oe == 4'h0)
    else $error("data lines driven outside read");
  chk_refused_write:
    assert property ($rose(write_strobe) && (chip_select_low || adr == 2'h3)
      |=> $stable(ctl) [*2]) else $error("refused write changed control");
  chk_tone_write:
    assert property (s_wr ##0 (adr == 2'h1) |-> ##[1:2]
      {tone_atten_6db, tone_enable} == {host_nibble_in[2], host_nibble_in[0]})
    else $error("tone write not taken");
  chk_path_write:
    assert property (s_wr ##0 (adr == 2'h2) |-> ##[1:2] tone_pair_from_term == host_nibble_in[0])
    else $error("path write not taken");
  chk_rx_mark:
    assert property (!carrier_seen |=> rx_bit_out) else $error("no mark without carrier");
  chk_rx_data:
    assert property (carrier_seen && $past(rst_n, 3) |=> rx_bit_out == $past(rx_demod_bit))
    else $error("receive bit wrong");
  chk_pair_low:
    assert property ($past(rst_n, 3) |=> tone_pair_detect_low == !$past(tone_pair_seen))
    else $error("pair detect wrong");
endmodule
bind mhnp_top mhnp_props i_mhnp_props (.*);

// *** tb/mhnp_host_model.sv ***
// Host side model resolving the shared nibble lines
module mhnp_host_model (
  input wire clk,
  input wire [3:0] drv,
  input wire drv_oe,
  input wire [3:0] dev_out,
  input wire [3:0] dev_oe,
  output logic [3:0] bus
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] last = 4'h0;
  // device drives on reads, host on writes, else churn
  always_comb bus = |dev_oe ? dev_out : drv_oe ? drv : ~last;
  always @(posedge clk) last <= bus;
endmodule

// *** tb/modem_host_nibble_port_test.sv ***
// Bench for the modem host nibble port
`include "mhnp_map.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
  $display("wrong value at %0t: %h not %h", $time, a, b); end end
module modem_host_nibble_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, chip_select_low = 1, read_strobe_low = 1, write_strobe = 0;
  logic [1:0] adr = 2'h0;
  logic [3:0] host_drv = 4'h0;
  logic host_oe = 0, rx_demod_bit = 1, carrier_seen = 0, progress_seen = 0, tone_pair_seen = 0;
  logic tx_bit = 1, osc_prev = 0;
  wire [3:0] bus, host_nibble_out, host_nibble_oe;
  wire rx_bit_out, detect_flag_low, tone_pair_detect_low, tone_enable, tone_atten_6db;
  wire tone_pair_from_term, power_down, fsk_wave, baud_tick, progress_tone, osc_clock_out;
  int fails = 0, total_checks = 0, n = 0, m = 0;
  mhnp_top i_mhnp_top (.clk(clk), .rst_n(rst_n), .chip_select_low(chip_select_low),
    .read_strobe_low(read_strobe_low), .write_strobe(write_strobe),
    .addr_line_zero(adr[0]), .addr_line_one(adr[1]), .host_nibble_in(bus),
    .host_nibble_out(host_nibble_out), .host_nibble_oe(host_nibble_oe), .tx_bit_in(tx_bit),
    .rx_demod_bit(rx_demod_bit), .carrier_seen(carrier_seen), .progress_seen(progress_seen),
    .tone_pair_seen(tone_pair_seen), .rx_bit_out(rx_bit_out), .detect_flag_low(detect_flag_low),
    .tone_pair_detect_low(tone_pair_detect_low), .fsk_wave(fsk_wave), .baud_tick(baud_tick),
    .progress_tone(progress_tone), .tone_enable(tone_enable), .tone_atten_6db(tone_atten_6db),
    .tone_pair_from_term(tone_pair_from_term), .power_down(power_down),
    .osc_clock_out(osc_clock_out));
  mhnp_host_model i_mhnp_host_model (.clk(clk), .drv(host_drv), .drv_oe(host_oe),
    .dev_out(host_nibble_out), .dev_oe(host_nibble_oe), .bus(bus));
  // Clock of 40 ns
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Host write, strobe rise with data held
  task automatic wr(input logic [1:0] a, input logic [3:0] d, input logic cs = 0);
    @(posedge clk);
    adr <= a; host_drv <= d; host_oe <= 1; chip_select_low <= cs;
    @(posedge clk) write_strobe <= 1;
    repeat (3) @(posedge clk);
    write_strobe <= 0; host_oe <= 0; chip_select_low <= 1;
    tick(1);
  endtask
  // Host read and compare
  task automatic rchk(input logic [1:0] a, input logic [3:0] e);
    @(posedge clk);
    adr <= a; chip_select_low <= 0; read_strobe_low <= 0;
    tick(2);
    `CHK(bus, e)
    @(posedge clk);
    chip_select_low <= 1; read_strobe_low <= 1;
    tick(1);
  endtask
  // Within a 1/64 band of the nominal count
  function automatic bit near(input int cnt, input int nom);
    return cnt >= nom - nom / 64 && cnt <= nom + nom / 64;
  endfunction
  // Cycles until the chosen wave or tick is seen high, capped
  task automatic cyc_to_high(input int sel, output int cnt);
    logic hit;
    cnt = 0;
    hit = 1'b0;
    while (!hit && cnt < 40000) begin
      tick(1);
      cnt++;
      hit = (sel == 0) ? fsk_wave : (sel == 1) ? baud_tick : progress_tone;
    end
  endtask
  task automatic final_report;
    if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    tick(12);
    rst_n <= 1;
    tick(4);
    for (int i = 0; i < 3; i++) rchk(i[1:0], `MHNP_CTRL_RESET);
    `CHK(({rx_bit_out, detect_flag_low, tone_pair_detect_low}), 3'h7)
    wr(`MHNP_ADDR_TONE, 4'h5);
    rchk(`MHNP_ADDR_TONE, 4'h5);
    `CHK(({tone_atten_6db, tone_enable}), 2'h3)
    wr(`MHNP_ADDR_TONE, 4'ha, 1'b1);
    rchk(`MHNP_ADDR_TONE, 4'h5);
    wr(`MHNP_ADDR_PATH, 4'h1);
    `CHK(tone_pair_from_term, 1'b1)
    wr(`MHNP_ADDR_STAT, 4'hf);
    rchk(`MHNP_ADDR_STAT, 4'h0);
    carrier_seen <= 1; tone_pair_seen <= 1; rx_demod_bit <= 0;
    tick(3);
    `CHK(({rx_bit_out, detect_flag_low, tone_pair_detect_low}), 3'h0)
    rchk(`MHNP_ADDR_STAT, 4'h5);
    wr(`MHNP_ADDR_MODE, 4'h1);
    `CHK(detect_flag_low, 1'b1)
    progress_seen <= 1;
    tick(3);
    `CHK(detect_flag_low, 1'b0)
    wr(`MHNP_ADDR_MODE, 4'h2);
    `CHK(power_down, 1'b1)
    // Oscillator output rises over 1000 cycles
    osc_prev = osc_clock_out;
    n = 0;
    repeat (1000) begin
      tick(1);
      n += (osc_clock_out && !osc_prev) ? 1 : 0;
      osc_prev = osc_clock_out;
    end
    `CHK(near(n, `MHNP_OSC_HZ / (`MHNP_CLK_HZ / 1000)), 1'b1)
    // Power up from zero phase: mark half period, then first baud tick
    tx_bit <= 1'b0;
    wr(`MHNP_ADDR_MODE, 4'h0);
    cyc_to_high(0, n);
    `CHK(near(n, `MHNP_CLK_HZ / (2 * `MHNP_MARK_HZ)), 1'b1)
    cyc_to_high(1, m);
    `CHK(near(n + m, `MHNP_CLK_HZ / `MHNP_BAUD), 1'b1)
    // Space now latched; restart phase and time the half period
    wr(`MHNP_ADDR_MODE, 4'h2);
    wr(`MHNP_ADDR_MODE, 4'h0);
    cyc_to_high(0, n);
    `CHK(near(n, `MHNP_CLK_HZ / (2 * `MHNP_SPACE_HZ)), 1'b1)
    // Progress tone half periods, high then low choice
    wr(`MHNP_ADDR_TONE, 4'ha);
    cyc_to_high(2, n);
    `CHK(near(n, `MHNP_CLK_HZ / (2 * `MHNP_CPT_HI_HZ)), 1'b1)
    wr(`MHNP_ADDR_TONE, 4'h0);
    wr(`MHNP_ADDR_TONE, 4'h8);
    cyc_to_high(2, n);
    `CHK(near(n, `MHNP_CLK_HZ / (2 * `MHNP_CPT_LO_HZ)), 1'b1)
    final_report;
  end
  // Watchdog against a hang
  initial begin
    tick(90000);
    fails++;
    final_report;
  end
endmodule
